/* File: core/spba_pkg.sv */
/*
 * Shared constants, register layouts, carriers and states of the secondary bus arbiter.
 * Assumes byte-wide configuration accesses and a single secondary PCI clock.
 */
package spba_pkg;
	// ********************************
	// Register offsets and reset values
	// ********************************
	localparam logic [7:0] ARBITER_CONTROL_OFS = 8'hDC; // Control byte offset.
	localparam logic [7:0] ARBITER_REQUEST_MASK_OFS = 8'hDD; // Mask byte offset.
	localparam logic [7:0] ARBITER_TIMEOUT_STATUS_OFS = 8'hDE; // Status byte offset.
	localparam logic [7:0] ARBITER_CONTROL_RST = 8'h40; // Bridge sits in the high tier.
	localparam logic [7:0] ARBITER_REQUEST_MASK_RST = 8'h00; // No request ignored; wait limit and auto mask off.
	localparam logic [7:0] READ_ZERO = 8'h00; // Answer for unmapped offsets.

	// ********************************
	// Masters and timing
	// ********************************
	localparam int N_MASTERS = 2; // Bridge and firewire controller.
	localparam int MASTER_BRIDGE = 0; // Request and grant bit of the bridge.
	localparam int MASTER_FIREWIRE = 1; // Request and grant bit of the controller.
	localparam int GRANT_WAIT_PCI_CLOCKS = 16; // Wait limit in PCI clocks.
	localparam int CYCLES_PER_PCI_CLOCK = 1; // The arbiter runs on the PCI clock.
	localparam int GRANT_WAIT_CYCLES = GRANT_WAIT_PCI_CLOCKS * CYCLES_PER_PCI_CLOCK;
	localparam logic [3:0] WAIT_LAST = 4'(GRANT_WAIT_CYCLES - 1); // Final idle count.

	// ********************************
	// Carriers
	// ********************************
	typedef struct packed {
		logic park_on_bridge; // Park on the bridge instead of the last owner.
		logic bridge_priority_level; // Bridge in the high tier when set.
		logic [4:0] unused_bits; // Kept at zero by software.
		logic firewire_ctrl_priority_level; // Controller in the high tier when set.
	} spba_control_t;

	typedef struct packed {
		logic grant_wait_limit_enable; // Enables the idle wait limit.
		logic auto_mask_enable; // Masks a master that let the limit expire.
		logic [4:0] unused_bits; // Kept at zero by software.
		logic firewire_ctrl_request_ignore; // Ignore controller requests.
	} spba_mask_t;

	typedef struct packed {
		logic rd; // One-cycle read strobe.
		logic wr; // One-cycle write strobe.
		logic [7:0] addr; // Byte offset in configuration space.
		logic [7:0] wdata; // Write data.
	} spba_cfg_req_t;

	typedef enum logic {SPBA_ST_IDLE, SPBA_ST_BUSY} spba_state_t;
endpackage : spba_pkg

/* File: core/spba_rr_tier.sv */
/*
 * One rotating-priority tier: picks the first request after the last owner.
 * Assumes the request vector is already filtered by masks and tier membership.
 */
`timescale 1ns/1ps
`default_nettype none
module spba_rr_tier #(
	parameter int N = 2
) (
	input wire logic [N-1:0] req,
	input wire logic [$clog2(N)-1:0] last_idx,
	output logic [N-1:0] pick
);
	// ********************************
	// Rotation search
	// ********************************
	// The far positions are tried first so that the nearest one after the owner wins.
	always_comb begin
		int idx;
		idx = 0;
		pick = '0;
		for (int i = N; i >= 1; i--) begin
			idx = (int'(last_idx) + i) % N;
			if (req[idx]) begin
				pick = '0;
				pick[idx] = 1'b1;
			end
		end
	end
endmodule : spba_rr_tier
`default_nettype wire

/* File: core/spba_arbiter.sv */
/*
 * Secondary PCI bus arbiter with its three configuration bytes.
 * Assumes frame_n and irdy_n come from pins, requests and the configuration port
 * from logic on the same clock, and both resets other than reset_n from pins.
 */
`timescale 1ns/1ps
`default_nettype none
module spba_arbiter (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clock_en,
	input wire logic perst_n,
	input wire logic global_reset_input_n,
	input wire spba_pkg::spba_cfg_req_t cfg,
	output logic [7:0] cfg_rdata,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic bridge_request,
	input wire logic firewire_ctrl_request,
	output logic bridge_grant,
	output logic firewire_ctrl_grant
);
	// ********************************
	// Pin synchronisers
	// ********************************
	logic [3:0] sync_a; // First stages, read only by the second stages.
	logic [3:0] sync_b; // Second stages: perst, global reset, frame, irdy.

	// Resets synchronise to zero so the registers are cleared right after release.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sync_a <= 4'h3;
			sync_b <= 4'h3;
		end else if (clock_en) begin
			sync_a <= {perst_n, global_reset_input_n, frame_n, irdy_n};
			sync_b <= sync_a;
		end
	end

	logic soft_clear; // Either pin reset is active.
	logic bus_idle; // Neither frame nor irdy is asserted.
	assign soft_clear = !sync_b[3] || !sync_b[2];
	assign bus_idle = sync_b[1] && sync_b[0];

	// ********************************
	// State declarations
	// ********************************
	spba_pkg::spba_control_t arbiter_control; // Tier and parking control.
	spba_pkg::spba_mask_t arbiter_request_mask; // Masking and wait limit control.
	logic firewire_ctrl_expired_flag; // Sticky expiry of the controller.
	logic [1:0] auto_masked; // Masters blocked after an expiry.
	spba_pkg::spba_state_t st; // Bus idle or carrying a transaction.
	logic [1:0] grant; // One-hot grant, bridge in bit 0.
	logic last_owner; // Index of the most recent bus master.
	logic [3:0] wait_cnt; // Idle clocks seen by the current grantee.
	logic [5:0] grant_hist; // Grants of the last three cycles, oldest in the top bits.
	logic [5:0] next_grant_hist;
	spba_pkg::spba_control_t next_arbiter_control;
	spba_pkg::spba_mask_t next_arbiter_request_mask;
	logic next_firewire_ctrl_expired_flag;
	logic [1:0] next_auto_masked;
	logic [7:0] next_cfg_rdata;
	spba_pkg::spba_state_t next_st;
	logic [1:0] next_grant;
	logic next_last_owner;
	logic [3:0] next_wait_cnt;

	// ********************************
	// Request filtering and tier pick
	// ********************************
	logic [1:0] req; // Raw requests.
	logic [1:0] elig; // Requests that may win.
	logic [1:0] high; // Tier membership, one for the high tier.
	logic [1:0] pick_high; // Winner of the high tier.
	logic [1:0] pick_low; // Winner of the low tier.
	logic [1:0] arb_pick; // Overall winner.
	logic [1:0] park_pick; // Owner of an idle bus.
	logic arb_go; // The grant may move this cycle.
	logic waiting; // A granted requester has not started yet.
	logic expire; // The wait limit ran out this cycle.
	logic status_read; // Software reads the status byte.

	assign req = {firewire_ctrl_request, bridge_request};
	// Software and automatic masks remove a requester before either tier looks at it.
	assign elig = req & ~{arbiter_request_mask.firewire_ctrl_request_ignore, 1'b0}
		& ~auto_masked;
	assign high = {arbiter_control.firewire_ctrl_priority_level,
		arbiter_control.bridge_priority_level};

	spba_rr_tier #(.N(spba_pkg::N_MASTERS)) u_high (
		.req(elig & high),
		.last_idx(last_owner),
		.pick(pick_high)
	);

	spba_rr_tier #(.N(spba_pkg::N_MASTERS)) u_low (
		.req(elig & ~high),
		.last_idx(last_owner),
		.pick(pick_low)
	);

	// The high tier always wins; rotation happens within a tier only.
	assign arb_pick = (|pick_high) ? pick_high : pick_low;
	assign park_pick = (arbiter_control.park_on_bridge || !last_owner) ? 2'b01 : 2'b10;
	assign arb_go = (st == spba_pkg::SPBA_ST_IDLE) && bus_idle && !soft_clear;
	assign waiting = arb_go && |(grant & elig);
	assign expire = waiting && arbiter_request_mask.grant_wait_limit_enable
		&& (wait_cnt == spba_pkg::WAIT_LAST);
	assign status_read = cfg.rd && (cfg.addr == spba_pkg::ARBITER_TIMEOUT_STATUS_OFS);

	// ********************************
	// Configuration registers
	// ********************************
	// Writes land in the control or mask byte at the strobed offset; other offsets, the status byte included, are ignored.
	always_comb begin
		next_arbiter_control = arbiter_control;
		next_arbiter_request_mask = arbiter_request_mask;
		next_cfg_rdata = cfg_rdata;
		next_auto_masked = auto_masked & req;
		next_firewire_ctrl_expired_flag = firewire_ctrl_expired_flag && !status_read;
		if (cfg.wr && cfg.addr == spba_pkg::ARBITER_CONTROL_OFS) begin
			next_arbiter_control = cfg.wdata;
		end
		if (cfg.wr && cfg.addr == spba_pkg::ARBITER_REQUEST_MASK_OFS) begin
			next_arbiter_request_mask = cfg.wdata;
		end
		if (cfg.rd) begin
			unique case (cfg.addr)
				spba_pkg::ARBITER_CONTROL_OFS: next_cfg_rdata = arbiter_control;
				spba_pkg::ARBITER_REQUEST_MASK_OFS: next_cfg_rdata = arbiter_request_mask;
				spba_pkg::ARBITER_TIMEOUT_STATUS_OFS: begin
					next_cfg_rdata = {7'h00, firewire_ctrl_expired_flag};
				end
				default: next_cfg_rdata = spba_pkg::READ_ZERO;
			endcase
		end
		// A new expiry beats a read in the same cycle so it is never lost.
		if (expire && grant[spba_pkg::MASTER_FIREWIRE]) begin
			next_firewire_ctrl_expired_flag = 1'b1;
		end
		if (expire && arbiter_request_mask.auto_mask_enable) begin
			next_auto_masked = next_auto_masked | grant;
		end
		if (soft_clear) begin
			next_arbiter_control = spba_pkg::ARBITER_CONTROL_RST;
			next_arbiter_request_mask = spba_pkg::ARBITER_REQUEST_MASK_RST;
			next_firewire_ctrl_expired_flag = 1'b0;
			next_auto_masked = 2'b00;
			next_cfg_rdata = spba_pkg::READ_ZERO;
		end
	end

	// Power-on reset restores the same defaults as the pin resets.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			arbiter_control <= spba_pkg::ARBITER_CONTROL_RST;
			arbiter_request_mask <= spba_pkg::ARBITER_REQUEST_MASK_RST;
			firewire_ctrl_expired_flag <= 1'b0;
			auto_masked <= 2'b00;
			cfg_rdata <= spba_pkg::READ_ZERO;
		end else if (clock_en) begin
			arbiter_control <= next_arbiter_control;
			arbiter_request_mask <= next_arbiter_request_mask;
			firewire_ctrl_expired_flag <= next_firewire_ctrl_expired_flag;
			auto_masked <= next_auto_masked;
			cfg_rdata <= next_cfg_rdata;
		end
	end

	// ********************************
	// Grant sequencing
	// ********************************
	// The grant moves only while the bus is idle; a started transaction holds it.
	always_comb begin
		next_st = st;
		next_grant = grant;
		next_last_owner = last_owner;
		next_wait_cnt = 4'h0;
		next_grant_hist = {grant_hist[3:0], grant};
		unique case (st)
			spba_pkg::SPBA_ST_IDLE: begin
				// Frame reaches this point two edges after the master sampled its grant.
				// The grant may have moved on by then, so the owner is the grant of that time.
				if (!sync_b[1] && |grant_hist[5:4]) begin
					next_st = spba_pkg::SPBA_ST_BUSY;
					next_last_owner = grant_hist[4 + spba_pkg::MASTER_FIREWIRE];
				end else if (bus_idle) begin
					next_grant = (|elig) ? arb_pick : park_pick;
					// A grant that moves restarts the wait for the new owner.
					if (waiting && !expire && next_grant == grant) begin
						next_wait_cnt = wait_cnt + 4'h1;
					end
				end
			end
			spba_pkg::SPBA_ST_BUSY: begin
				if (bus_idle) begin
					next_st = spba_pkg::SPBA_ST_IDLE;
				end
			end
		endcase
		if (soft_clear) begin
			next_st = spba_pkg::SPBA_ST_IDLE;
			next_grant = 2'b00;
			next_last_owner = 1'b0;
			next_grant_hist = 6'h00;
		end
	end

	// Register stage of the grant sequencer.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st <= spba_pkg::SPBA_ST_IDLE;
			grant <= 2'b00;
			last_owner <= 1'b0;
			wait_cnt <= 4'h0;
			grant_hist <= 6'h00;
		end else if (clock_en) begin
			grant_hist <= next_grant_hist;
			st <= next_st;
			grant <= next_grant;
			last_owner <= next_last_owner;
			wait_cnt <= next_wait_cnt;
		end
	end

	assign bridge_grant = grant[spba_pkg::MASTER_BRIDGE];
	assign firewire_ctrl_grant = grant[spba_pkg::MASTER_FIREWIRE];

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n || !clock_en);

	sequence s_fw_expire;
		expire && grant[1];
	endsequence
	sequence s_flag_up;
		firewire_ctrl_expired_flag;
	endsequence

	chk_high_tier_wins: assert property (arb_go && elig == 2'b11 && high == 2'b01 |=> grant == 2'b01)
		else $error("high tier bridge lost to low tier");
	chk_fw_tier_wins: assert property (arb_go && elig == 2'b11 && high == 2'b10 |=> grant == 2'b10)
		else $error("high tier controller lost");
	chk_tier_rotation: assert property (arb_go && elig == 2'b11 && high[0] == high[1] && !last_owner
		|=> grant == 2'b10)
		else $error("rotation did not pass to the other master");
	chk_park_owner: assert property (arb_go && elig == 2'b00 |=> grant == $past(park_pick))
		else $error("idle bus parked on wrong master");
	chk_wait_limit: assert property (expire |-> wait_cnt == 4'hF && $past(waiting, 1))
		else $error("expiry before sixteen idle clocks");
	chk_no_limit_off: assert property (!arbiter_request_mask.grant_wait_limit_enable |-> !expire)
		else $error("expiry while the limit is off");
	chk_auto_mask_set: assert property (expire && arbiter_request_mask.auto_mask_enable && !soft_clear
		|=> |(auto_masked & $past(grant)))
		else $error("expired master not masked");
	chk_fw_ignored: assert property (arbiter_request_mask.firewire_ctrl_request_ignore |-> !elig[1])
		else $error("ignored controller request still eligible");
	chk_flag_sets: assert property (s_fw_expire ##0 !soft_clear |=> s_flag_up)
		else $error("controller expiry not flagged");
	chk_flag_read_clear: assert property (status_read && !expire && !soft_clear
		|=> !firewire_ctrl_expired_flag && cfg_rdata == {7'h00, $past(firewire_ctrl_expired_flag)})
		else $error("status read did not return and clear flag");
	chk_defaults_restore: assert property (soft_clear |=> arbiter_control == 8'h40
		&& arbiter_request_mask == 8'h00)
		else $error("pin reset left registers changed");
	chk_skip_masked: assert property (arb_go && |elig |=> |(grant & $past(elig)))
		else $error("grant went to a masked requester");
endmodule : spba_arbiter
`default_nettype wire

/* File: sim/spba_master_model.sv */
/*
 * Behavioural masters on the secondary bus: the bridge and the controller.
 * Assumes the arbiter's clock and grants; frame and irdy are driven high when released.
 */
`timescale 1ns/1ps
`default_nettype none
module spba_master_model (
	input wire logic clock,
	input wire logic [1:0] want,
	input wire logic resp,
	input wire logic [1:0] grant,
	output logic [1:0] req,
	output logic frame_n,
	output logic irdy_n,
	output logic busy
);
	// ********************************
	// Transaction engine
	// ********************************
	logic [2:0] cnt = 3'h0; // Data phase counter, zero while the bus is free.
	logic [1:0] used = 2'h0; // One transaction for each raised request.

	// A served master drops its request until the bench lowers its wish.
	assign req = want & ~used;
	assign busy = (cnt != 3'h0);
	// Released lines are driven back high by the model itself.
	assign frame_n = !(cnt inside {3'h1, 3'h2, 3'h3});
	assign irdy_n = !busy;

	// A master starts only when granted, requesting and told to answer.
	always @(posedge clock) begin
		if (busy) begin
			cnt <= (cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
			used <= used & want;
		end else if (resp && |(grant & req)) begin
			cnt <= 3'h1;
			used <= (used & want) | (grant & req);
		end else begin
			used <= used & want;
		end
	end
endmodule : spba_master_model
`default_nettype wire

/* File: sim/secondary_pci_bus_arbiter_tb_top.sv */
/*
 * Self-checking bench of the secondary bus arbiter.
 * Assumes the design package, the arbiter and the master model compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module secondary_pci_bus_arbiter_tb_top;
	logic clock = 1'b0;
	logic reset_n;
	logic perst_n;
	logic global_reset_input_n;
	spba_pkg::spba_cfg_req_t cfg;
	logic [7:0] cfg_rdata;
	logic frame_n;
	logic irdy_n;
	logic [1:0] req; // Bit 0 bridge, bit 1 controller.
	logic [1:0] grant; // Same order as the requests.
	logic [1:0] want; // Which masters the bench wants on the bus.
	logic resp; // Masters answer a grant with a transaction.
	logic busy;
	int n_fail = 0;
	int n_tests = 0;

	// ********************************
	// Design, masters and clock
	// ********************************
	spba_arbiter i_dut (.clock(clock), .reset_n(reset_n), .clock_en(1'b1),
		.perst_n(perst_n), .global_reset_input_n(global_reset_input_n),
		.cfg(cfg), .cfg_rdata(cfg_rdata), .frame_n(frame_n), .irdy_n(irdy_n),
		.bridge_request(req[0]), .firewire_ctrl_request(req[1]),
		.bridge_grant(grant[0]), .firewire_ctrl_grant(grant[1]));
	spba_master_model i_masters (.clock(clock), .want(want), .resp(resp),
		.grant(grant), .req(req), .frame_n(frame_n), .irdy_n(irdy_n), .busy(busy));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// ********************************
	// Shared tasks
	// ********************************
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		cfg = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(negedge clock);
		cfg = '0;
	endtask : wr

	// Read data lands one edge after the strobe, so it is settled here.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clock);
		cfg = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(negedge clock);
		cfg = '0;
		cmp(cfg_rdata, exp);
	endtask : rd

	// Bounded wait, since the grant follows bus idle through synchronisers.
	task automatic gnt(input logic [1:0] exp);
		for (int i = 0; i < 40 && grant !== exp; i++) @(negedge clock);
		cmp({6'h00, grant}, {6'h00, exp});
	endtask : gnt

	task automatic hold(input logic [1:0] exp);
		repeat (10) @(negedge clock);
		cmp({6'h00, grant}, {6'h00, exp});
	endtask : hold

	task automatic xfer;
		for (int i = 0; i < 20 && !busy; i++) @(negedge clock);
		for (int i = 0; i < 20 && busy; i++) @(negedge clock);
	endtask : xfer

	task automatic done(input string s);
		$display("%s finished, failures so far %0d", s, n_fail);
	endtask : done

	// ********************************
	// Scenarios
	// ********************************
	task automatic t_regs;
		rd(8'hDC, spba_pkg::ARBITER_CONTROL_RST);
		rd(8'hDD, 8'h00);
		rd(8'hDE, 8'h00);
		rd(8'hD9, 8'h00);
		wr(8'hDC, 8'hC1);
		rd(8'hDC, 8'hC1);
		wr(8'hDE, 8'hFF);
		rd(8'hDE, 8'h00);
		wr(8'hDC, 8'h40);
		done("regs");
	endtask : t_regs

	task automatic t_park;
		hold(2'b01);
		want = 2'b10;
		resp = 1'b1;
		gnt(2'b10);
		xfer();
		want = 2'b00;
		hold(2'b10);
		wr(8'hDC, 8'hC0);
		gnt(2'b01);
		wr(8'hDC, 8'h40);
		done("park");
	endtask : t_park

	task automatic t_tier;
		resp = 1'b0;
		want = 2'b11;
		gnt(2'b01);
		wr(8'hDC, 8'h01);
		gnt(2'b10);
		wr(8'hDC, 8'h41);
		gnt(2'b01);
		resp = 1'b1;
		xfer();
		resp = 1'b0;
		want = 2'b00;
		@(negedge clock);
		want = 2'b11;
		hold(2'b10);
		want = 2'b00;
		wr(8'hDC, 8'hC0);
		done("tier");
	endtask : t_tier

	task automatic t_mask;
		wr(8'hDD, 8'h01);
		want = 2'b10;
		hold(2'b01);
		wr(8'hDD, 8'h00);
		gnt(2'b10);
		want = 2'b00;
		done("mask");
	endtask : t_mask

	// The controller never answers its grant, so the wait limit runs out.
	task automatic t_timeout;
		wr(8'hDD, 8'h80);
		want = 2'b10;
		gnt(2'b10);
		repeat (8) @(negedge clock);
		rd(8'hDE, 8'h00);
		repeat (8) @(negedge clock);
		rd(8'hDE, 8'h01);
		rd(8'hDE, 8'h00);
		cmp({6'h00, grant}, 8'h02);
		want = 2'b00;
		wr(8'hDD, 8'hC0);
		want = 2'b10;
		gnt(2'b10);
		gnt(2'b01);
		rd(8'hDE, 8'h01);
		want = 2'b00;
		@(negedge clock);
		want = 2'b10;
		gnt(2'b10);
		want = 2'b00;
		wr(8'hDD, 8'h00);
		done("timeout");
	endtask : t_timeout

	task automatic t_pins;
		for (int i = 0; i < 2; i++) begin
			wr(8'hDC, 8'hC1);
			wr(8'hDD, 8'h41);
			if (i == 0) begin
				perst_n = 1'b0;
			end else begin
				global_reset_input_n = 1'b0;
			end
			repeat (4) @(negedge clock);
			perst_n = 1'b1;
			global_reset_input_n = 1'b1;
			repeat (6) @(negedge clock);
			rd(8'hDC, 8'h40);
			rd(8'hDD, 8'h00);
		end
		done("pins");
	endtask : t_pins

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report

	// ********************************
	// Main sequence and watchdog
	// ********************************
	initial begin
		reset_n = 1'b0;
		perst_n = 1'b1;
		global_reset_input_n = 1'b1;
		cfg = '0;
		want = 2'b00;
		resp = 1'b0;
		repeat (8) @(negedge clock);
		reset_n = 1'b1;
		repeat (4) @(negedge clock);
		t_regs();
		t_park();
		t_tier();
		t_mask();
		t_timeout();
		t_pins();
		final_report();
	end

	// The scenarios need well under a thousand cycles; this is five times that.
	initial begin
		#(40 * 5000);
		n_fail++;
		final_report();
	end
endmodule : secondary_pci_bus_arbiter_tb_top
`default_nettype wire
